// ==== hdl/rcs_defines.svh ====
// offsets, field positions, reset values and counts of the startup sequencer
`ifndef RCS_DEFINES_SVH
`define RCS_DEFINES_SVH

// ******************************************************************
// register byte offsets
// ******************************************************************
`define RCS_OFS_HOST_CONTROL 5'h00
`define RCS_OFS_MCU_CONTROL 5'h04
`define RCS_OFS_CLOCK_SELECT 5'h08
`define RCS_OFS_DISP_PENDING 5'h0c
`define RCS_OFS_DISP_ACTIVE 5'h10
`define RCS_OFS_EVENT_STATUS 5'h14
`define RCS_OFS_SYS_STATUS 5'h18

// ******************************************************************
// field positions
// ******************************************************************
`define RCS_BIT_SOFT_RESET 0
`define RCS_BIT_MCU_ENABLE 0
`define RCS_FLD_DSYN_LO 0
`define RCS_FLD_DSYN_HI 1
`define RCS_FLD_FRAME_CLOCK_LO 2
`define RCS_FLD_FRAME_CLOCK_HI 3
`define RCS_BIT_ST_LOCK 0
`define RCS_BIT_ST_SWITCHED 1
`define RCS_BIT_ST_MCU_RUN 2
`define RCS_BIT_ST_SOFT_BUSY 3
`define RCS_BIT_ST_AUTOSTART 4
`define RCS_BIT_ST_CLK_STRAP 5
`define RCS_BIT_ST_DOMAINS_UP 6

// ******************************************************************
// values and counts
// ******************************************************************
`define RCS_SOFT_RESET_START 1'h0
`define RCS_DISP_ACTIVE_RST 8'h00
`define RCS_DISP_PENDING_RST 8'h00
`define RCS_CLOCK_SELECT_RST 4'h0
`define RCS_DOMAIN_RST_CYCLES 64
`define RCS_CLK_GAP_CYCLES 4
`define RCS_PLL_MULT 4'ha
`define RCS_NUM_DOMAINS 4

`endif

// ==== hdl/rcs_pkg.sv ====
// types shared by the startup sequencer files
package rcs_pkg;

   // ******************************************************************
   // microcontroller clock switch states
   // ******************************************************************
   typedef enum logic [3:0] {
      MCS_HOLD = 4'h1,
      MCS_WAIT_LOCK = 4'h2,
      MCS_GAP = 4'h4,
      MCS_RUN = 4'h8
   } rcs_mclk_state_e;

   typedef logic [7:0] rcs_byte_t;

endpackage : rcs_pkg

// ==== hdl/rcs_domain_reset.sv ====
// reset stretcher for one clock domain
`timescale 1ns/10ps
`include "rcs_defines.svh"

module rcs_domain_reset #(
   parameter int HOLD_CYCLES = `RCS_DOMAIN_RST_CYCLES
) (
   input wire logic ref_clk,
   input wire logic hard_rst,
   input wire logic soft_start,
   output logic rst_q
);

   localparam int CW = $clog2(HOLD_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(HOLD_CYCLES - 1);

   logic [CW-1:0] cnt_q;

   // ******************************************************************
   // hold then count own cycles
   // ******************************************************************
   always_ff @(posedge ref_clk) begin
      if (hard_rst) begin
         rst_q <= 1'b1;
         cnt_q <= '0;
      end else if (soft_start) begin
         rst_q <= 1'b1;
         cnt_q <= '0;
      end else if (rst_q) begin
         if (cnt_q == LAST) begin
            rst_q <= 1'b0;
         end
         cnt_q <= cnt_q + CW'(1);
      end
   end

endmodule : rcs_domain_reset

// ==== hdl/rcs_top.sv ====
// reset and clock startup sequencer with avalon-mm register slave
//
// How it works
// - driving the hardware reset pin low returns every register to its default.
// - after hardware reset each domain stays in reset for 64 own cycles.
// - microcontroller clock runs from the reference clock during the reset period.
// - fast pll is told to multiply the reference clock by ten.
// - after pll lock, the mcu clock switches glitch-free to the strapped source.
// - mcu starts only if strapped to autostart, else waits for enable bit.
// - writing the documented value to soft reset starts it; bit self-clears.
// - soft reset clears active, clearable and read-only bits; keeps pending and rw.
// - pending value copies into active copy on an update event.
// - only the active copy drives logic; both resets clear it to default.
// - pending copy clears only on hardware reset; host writes it anytime.
// - clearable status bits are read-only, write one clears, resets clear them.
// - writes to read-only status bits are ignored.
// - soft reset holds each domain in reset 64 own cycles then resumes.
// - soft reset leaves analog pll, synth, receiver, converter and measure alone.
// - display synth and frame clock sources follow a host selection register.
// - frame store clock is always enabled, even with no external memory.
`timescale 1ns/10ps
`include "rcs_defines.svh"

module rcs_top #(
   parameter int NUM_DOMAINS = `RCS_NUM_DOMAINS,
   parameter int HOLD_CYCLES = `RCS_DOMAIN_RST_CYCLES,
   parameter int GAP_CYCLES = `RCS_CLK_GAP_CYCLES
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic hw_reset_pin_n,
   input wire logic boot_autostart,
   input wire logic boot_clk_pll,
   input wire logic pll_lock,
   input wire logic update_evt,
   input wire logic [7:0] status_evt,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [NUM_DOMAINS-1:0] domain_rst_q,
   output logic analog_rst_q,
   output logic input_format_measure_rst_q,
   output logic [3:0] pll_mult_q,
   output logic mcu_ref_gate_q,
   output logic mcu_pll_gate_q,
   output logic mcu_run_q,
   output logic [7:0] disp_ctrl_q,
   output logic [1:0] display_synth_src_q,
   output logic [1:0] frame_clock_src_q,
   output logic frame_store_clock_en_q
);

   // ******************************************************************
   // helpers
   // ******************************************************************
   function automatic logic [31:0] zext8(input logic [7:0] v);
      zext8 = {24'h000000, v};
   endfunction : zext8

   function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   localparam int GW = $clog2(GAP_CYCLES + 1);

   // ******************************************************************
   // reset pin synchroniser
   // ******************************************************************
   logic pin_s1_q;
   logic pin_s2_q;
   logic hw_rst;
   // only the second flop is read; the first may still be settling

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
      end else begin
         pin_s1_q <= hw_reset_pin_n;
         pin_s2_q <= pin_s1_q;
      end
   end

   // the whole block treats a low pin like the bus reset
   assign hw_rst = reset | ~pin_s2_q;

   // ******************************************************************
   // bootstrap straps, followed while in reset, frozen at release
   // ******************************************************************
   logic strap_auto_q;
   logic strap_pll_q;

   always_ff @(posedge ref_clk) begin
      if (hw_rst) begin
         strap_auto_q <= boot_autostart;
         strap_pll_q <= boot_clk_pll;
      end
   end

   // ******************************************************************
   // avalon-mm slave handshake
   // ******************************************************************
   // waitrequest drops for one cycle per request; the write is committed
   // at that same edge where the master sees it low
   logic req;
   logic wr_commit;
   logic [31:0] rd_mux;

   assign req = avs_read | avs_write;
   // every register lives in byte lane 0, so only that enable counts
   assign wr_commit = avs_write & ~avs_waitrequest & avs_byteenable[0];

   always_ff @(posedge ref_clk) begin
      if (hw_rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
      end else if (req && avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
         avs_readdata <= rd_mux;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   // ******************************************************************
   // soft reset control
   // ******************************************************************
   logic soft_start;
   logic soft_busy_q;
   logic domains_up;

   // a new request while one is running is ignored
   assign soft_start = wr_commit & hit(avs_address, `RCS_OFS_HOST_CONTROL)
      & (avs_writedata[`RCS_BIT_SOFT_RESET] == `RCS_SOFT_RESET_START)
      & ~soft_busy_q;

   assign domains_up = ~(|domain_rst_q);

   always_ff @(posedge ref_clk) begin
      if (hw_rst) begin
         soft_busy_q <= 1'b0;
      end else if (soft_start) begin
         soft_busy_q <= 1'b1;
      end else if (soft_busy_q && domains_up) begin
         soft_busy_q <= 1'b0;
      end
   end

   // ******************************************************************
   // per-domain reset stretchers
   // ******************************************************************
   for (genvar g = 0; g < NUM_DOMAINS; g++) begin : g_dom
      rcs_domain_reset #(
         .HOLD_CYCLES(HOLD_CYCLES)
      ) u_dom (
         .ref_clk(ref_clk),
         .hard_rst(hw_rst),
         .soft_start(soft_start),
         .rst_q(domain_rst_q[g])
      );
   end

   // analog parts and the format measure unit see hardware reset only
   always_ff @(posedge ref_clk) begin
      analog_rst_q <= hw_rst;
      input_format_measure_rst_q <= hw_rst;
   end

   // ******************************************************************
   // fast pll setup and frame store clock
   // ******************************************************************
   always_ff @(posedge ref_clk) begin
      pll_mult_q <= `RCS_PLL_MULT;
      // fifos inside need this clock even without external memory
      frame_store_clock_en_q <= 1'b1;
   end

   // ******************************************************************
   // microcontroller clock switch
   // ******************************************************************
   rcs_pkg::rcs_mclk_state_e mstate_q;
   logic [GW-1:0] gap_q;

   always_ff @(posedge ref_clk) begin
      if (hw_rst) begin
         mstate_q <= rcs_pkg::MCS_HOLD;
         gap_q <= '0;
         mcu_ref_gate_q <= 1'b1;
         mcu_pll_gate_q <= 1'b0;
      end else begin
         unique case (mstate_q)
            rcs_pkg::MCS_HOLD: begin
               if (domains_up) begin
                  mstate_q <= rcs_pkg::MCS_WAIT_LOCK;
               end
            end
            rcs_pkg::MCS_WAIT_LOCK: begin
               if (pll_lock) begin
                  // break before make so no runt pulse reaches the mcu
                  mcu_ref_gate_q <= ~strap_pll_q;
                  gap_q <= '0;
                  mstate_q <= strap_pll_q ? rcs_pkg::MCS_GAP : rcs_pkg::MCS_RUN;
               end
            end
            rcs_pkg::MCS_GAP: begin
               gap_q <= gap_q + GW'(1);
               if (gap_q == GW'(GAP_CYCLES - 1)) begin
                  mcu_pll_gate_q <= 1'b1;
                  mstate_q <= rcs_pkg::MCS_RUN;
               end
            end
            rcs_pkg::MCS_RUN: begin
               mstate_q <= rcs_pkg::MCS_RUN;
            end
         endcase
      end
   end

   // ******************************************************************
   // rw registers: untouched by soft reset
   // ******************************************************************
   logic mcu_enable_q;

   always_ff @(posedge ref_clk) begin
      if (hw_rst) begin
         mcu_enable_q <= 1'b0;
      end else if (wr_commit && hit(avs_address, `RCS_OFS_MCU_CONTROL)) begin
         mcu_enable_q <= avs_writedata[`RCS_BIT_MCU_ENABLE];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (hw_rst) begin
         {frame_clock_src_q, display_synth_src_q} <= `RCS_CLOCK_SELECT_RST;
      end else if (wr_commit && hit(avs_address, `RCS_OFS_CLOCK_SELECT)) begin
         display_synth_src_q <= avs_writedata[`RCS_FLD_DSYN_HI:`RCS_FLD_DSYN_LO];
         frame_clock_src_q <=
            avs_writedata[`RCS_FLD_FRAME_CLOCK_HI:`RCS_FLD_FRAME_CLOCK_LO];
      end
   end

   // ******************************************************************
   // microcontroller run gate
   // ******************************************************************
   always_ff @(posedge ref_clk) begin
      if (hw_rst) begin
         mcu_run_q <= 1'b0;
      end else begin
         // held off on a soft start so the mcu never rises into a fresh reset
         mcu_run_q <= (mstate_q == rcs_pkg::MCS_RUN) & domains_up & ~soft_start
            & (strap_auto_q | mcu_enable_q);
      end
   end

   // ******************************************************************
   // pending / active display control
   // ******************************************************************
   rcs_pkg::rcs_byte_t disp_pend_q;
   // pending bits ride through soft reset; only the pin or bus reset clears them

   always_ff @(posedge ref_clk) begin
      if (hw_rst) begin
         disp_pend_q <= `RCS_DISP_PENDING_RST;
      end else if (wr_commit && hit(avs_address, `RCS_OFS_DISP_PENDING)) begin
         disp_pend_q <= avs_writedata[7:0];
      end
   end

   // disp_ctrl_q is the only copy that leaves the block
   always_ff @(posedge ref_clk) begin
      if (hw_rst || soft_start) begin
         disp_ctrl_q <= `RCS_DISP_ACTIVE_RST;
      end else if (update_evt) begin
         disp_ctrl_q <= disp_pend_q;
      end
   end

   // ******************************************************************
   // clearable status: set wins over a clear in the same cycle
   // ******************************************************************
   rcs_pkg::rcs_byte_t evt_q;
   rcs_pkg::rcs_byte_t evt_clr;
   // a clear that meets a new event on the same bit loses, so no event is missed

   assign evt_clr = (wr_commit && hit(avs_address, `RCS_OFS_EVENT_STATUS))
      ? avs_writedata[7:0] : 8'h00;

   always_ff @(posedge ref_clk) begin
      if (hw_rst || soft_start) begin
         evt_q <= 8'h00;
      end else begin
         evt_q <= (evt_q & ~evt_clr) | status_evt;
      end
   end

   // ******************************************************************
   // read-only status, rebuilt every cycle from live state
   // ******************************************************************
   rcs_pkg::rcs_byte_t sys_st_q;

   // no write path reaches this register at all
   always_ff @(posedge ref_clk) begin
      if (hw_rst || soft_start) begin
         sys_st_q <= 8'h00;
      end else begin
         sys_st_q <= 8'h00;
         sys_st_q[`RCS_BIT_ST_LOCK] <= pll_lock;
         sys_st_q[`RCS_BIT_ST_SWITCHED] <= (mstate_q == rcs_pkg::MCS_RUN);
         sys_st_q[`RCS_BIT_ST_MCU_RUN] <= mcu_run_q;
         sys_st_q[`RCS_BIT_ST_SOFT_BUSY] <= soft_busy_q;
         sys_st_q[`RCS_BIT_ST_AUTOSTART] <= strap_auto_q;
         sys_st_q[`RCS_BIT_ST_CLK_STRAP] <= strap_pll_q;
         sys_st_q[`RCS_BIT_ST_DOMAINS_UP] <= domains_up;
      end
   end

   // ******************************************************************
   // read mux, unmapped offsets read zero
   // ******************************************************************
   always_comb begin
      rd_mux = 32'h00000000;
      unique case (avs_address)
         `RCS_OFS_HOST_CONTROL: rd_mux = zext8({7'h00, soft_busy_q});
         `RCS_OFS_MCU_CONTROL: rd_mux = zext8({7'h00, mcu_enable_q});
         `RCS_OFS_CLOCK_SELECT: begin
            rd_mux = zext8({4'h0, frame_clock_src_q, display_synth_src_q});
         end
         `RCS_OFS_DISP_PENDING: rd_mux = zext8(disp_pend_q);
         `RCS_OFS_DISP_ACTIVE: rd_mux = zext8(disp_ctrl_q);
         `RCS_OFS_EVENT_STATUS: rd_mux = zext8(evt_q);
         `RCS_OFS_SYS_STATUS: rd_mux = zext8(sys_st_q);
         default: rd_mux = 32'h00000000;
      endcase
   end

endmodule : rcs_top

// ==== sim/rcs_top_chk.sv ====
// concurrent checks on the startup sequencer ports
`timescale 1ns/10ps
`include "rcs_defines.svh"
module rcs_top_chk #(
   parameter int NUM_DOMAINS = 4,
   parameter int HOLD_CYCLES = 64
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic pll_lock,
   input wire logic update_evt,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic [NUM_DOMAINS-1:0] domain_rst_q,
   input wire logic analog_rst_q,
   input wire logic input_format_measure_rst_q,
   input wire logic [3:0] pll_mult_q,
   input wire logic mcu_ref_gate_q,
   input wire logic mcu_pll_gate_q,
   input wire logic mcu_run_q,
   input wire logic [7:0] disp_ctrl_q,
   input wire logic [1:0] display_synth_src_q,
   input wire logic frame_store_clock_en_q
);
   logic [9:0] hold_q;
   // saturates so a stuck domain reset cannot wrap back under the limit
   always_ff @(posedge ref_clk) begin
      if (reset || !domain_rst_q[0]) begin
         hold_q <= 10'h000;
      end else if (hold_q != 10'h3ff) begin
         hold_q <= hold_q + 10'h001;
      end
   end
   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   AST_HOLD: assert property ($fell(domain_rst_q[0]) |-> hold_q >= HOLD_CYCLES)
      else $error("domain reset too short");
   AST_EXCL: assert property (!(mcu_ref_gate_q && mcu_pll_gate_q))
      else $error("both mcu clock gates on");
   AST_GAP: assert property ($fell(mcu_ref_gate_q) |-> $past(pll_lock) ##0 !mcu_pll_gate_q [*3])
      else $error("clock switch without lock or gap");
   AST_HWCLK: assert property (analog_rst_q |-> ##1 mcu_ref_gate_q && !mcu_pll_gate_q && !mcu_run_q)
      else $error("mcu not on ref clock in reset");
   AST_RUN: assert property ($rose(mcu_run_q) |-> domain_rst_q == '0 && (mcu_ref_gate_q ^ mcu_pll_gate_q))
      else $error("mcu started too early");
   AST_MULT: assert property (pll_mult_q == `RCS_PLL_MULT)
      else $error("pll multiplier wrong");
   AST_FS: assert property (frame_store_clock_en_q)
      else $error("frame store clock off");
   AST_ACT: assert property (!$stable(disp_ctrl_q) |-> $past(update_evt) || domain_rst_q[0])
      else $error("active copy changed without cause");
   AST_SEL: assert property (!$stable(display_synth_src_q) |-> $past(avs_write) || analog_rst_q)
      else $error("clock select changed without write");
   AST_ANA: assert property (analog_rst_q == input_format_measure_rst_q)
      else $error("analog and measure resets differ");
   AST_ACK: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer late");
   cover property ($rose(domain_rst_q[0]) && !analog_rst_q);
   cover property ($rose(mcu_pll_gate_q));
   cover property ($rose(mcu_run_q));
endmodule : rcs_top_chk

bind rcs_top rcs_top_chk #(.NUM_DOMAINS(NUM_DOMAINS), .HOLD_CYCLES(HOLD_CYCLES)) chk_u (
   .ref_clk(ref_clk), .reset(reset), .pll_lock(pll_lock), .update_evt(update_evt),
   .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
   .domain_rst_q(domain_rst_q), .analog_rst_q(analog_rst_q),
   .input_format_measure_rst_q(input_format_measure_rst_q),
   .pll_mult_q(pll_mult_q), .mcu_ref_gate_q(mcu_ref_gate_q), .mcu_pll_gate_q(mcu_pll_gate_q),
   .mcu_run_q(mcu_run_q), .disp_ctrl_q(disp_ctrl_q),
   .display_synth_src_q(display_synth_src_q), .frame_store_clock_en_q(frame_store_clock_en_q));

// ==== sim/rcs_pin_src.sv ====
// reset pin source and pll lock model facing the sequencer
`timescale 1ns/10ps
module rcs_pin_src #(
   parameter int LOW_CYCLES = 60
) (
   input wire logic ref_clk,
   input wire logic pulse_req,
   input wire logic [7:0] lock_dly,
   output logic hw_reset_pin_n,
   output logic pll_lock
);
   int low_cnt = LOW_CYCLES;
   int lock_cnt = 0;
   initial begin
      hw_reset_pin_n = 1'b0;
      pll_lock = 1'b0;
   end
   // 60 cycles of 20 ns keep the pin low 1.2 us, past the 1 us minimum
   always @(posedge ref_clk) begin
      if (pulse_req) begin
         low_cnt <= LOW_CYCLES;
      end else if (low_cnt > 0) begin
         low_cnt <= low_cnt - 1;
      end
      hw_reset_pin_n <= (low_cnt == 0) && !pulse_req;
      lock_cnt <= hw_reset_pin_n ? lock_cnt + 1 : 0;
      pll_lock <= hw_reset_pin_n && (lock_cnt >= lock_dly);
   end
endmodule : rcs_pin_src

// ==== sim/tb_top.sv ====
// self-checking bench for the startup sequencer
`timescale 1ns/10ps
`include "rcs_defines.svh"
module tb_top;
   logic ref_clk, reset, hw_reset_pin_n, boot_autostart, boot_clk_pll, pll_lock;
   logic update_evt, avs_read, avs_write, avs_waitrequest, analog_rst_q;
   logic input_format_measure_rst_q, frame_store_clock_en_q;
   logic mcu_ref_gate_q, mcu_pll_gate_q, mcu_run_q, pin_req;
   logic [7:0] status_evt, disp_ctrl_q, lock_dly;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [3:0] avs_byteenable, pll_mult_q, domain_rst_q, mon;
   logic [1:0] display_synth_src_q, frame_clock_src_q;
   int err_count = 0;
   int total_checks = 0;
   int seed = 59;
   int n, ana_cnt, ana_ref, m_pend, m_stat, m_sel, w;
   assign mon = {mcu_run_q, mcu_pll_gate_q, hw_reset_pin_n, |domain_rst_q};
   rcs_top dut_u (.ref_clk(ref_clk), .reset(reset), .hw_reset_pin_n(hw_reset_pin_n),
      .boot_autostart(boot_autostart), .boot_clk_pll(boot_clk_pll), .pll_lock(pll_lock),
      .update_evt(update_evt), .status_evt(status_evt), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .domain_rst_q(domain_rst_q),
      .analog_rst_q(analog_rst_q), .input_format_measure_rst_q(input_format_measure_rst_q),
      .pll_mult_q(pll_mult_q),
      .mcu_ref_gate_q(mcu_ref_gate_q), .mcu_pll_gate_q(mcu_pll_gate_q), .mcu_run_q(mcu_run_q),
      .disp_ctrl_q(disp_ctrl_q), .display_synth_src_q(display_synth_src_q),
      .frame_clock_src_q(frame_clock_src_q),
      .frame_store_clock_en_q(frame_store_clock_en_q));
   rcs_pin_src src_u (.ref_clk(ref_clk), .pulse_req(pin_req), .lock_dly(lock_dly),
      .hw_reset_pin_n(hw_reset_pin_n), .pll_lock(pll_lock));
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk; // 50 MHz, never stopped by reset
   end
   always @(posedge ref_clk) if (analog_rst_q === 1'b1) ana_cnt++;
   // ****************************************
   // tasks
   // ****************************************
   task test_done;
      if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : test_done
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   // request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      int k;
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= !wr;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 40);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (k >= 40) begin
         chk(32'h1, 32'h0);
         test_done();
      end
   endtask : bus
   task automatic rchk(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 4'hf);
      chk(rd, e);
   endtask : rchk
   task automatic wait_for(input int s, input logic v);
      n = 0;
      while (mon[s] !== v && n < 2000) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 2000) begin
         chk(32'h1, 32'h0);
         test_done();
      end
   endtask : wait_for
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      reset = 1'b1;
      pin_req = 1'b0;
      lock_dly = 8'hc8;
      boot_autostart = 1'b0;
      boot_clk_pll = 1'b1;
      update_evt = 1'b0;
      status_evt = 8'h00;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
      ana_cnt = 0;
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      wait_for(0, 1'b0);
      chk(pll_mult_q, `RCS_PLL_MULT);
      chk(frame_store_clock_en_q, 1'b1);
      for (int i = 0; i < 8; i++) begin
         if (i != 6) rchk(5'(i * 4), 32'h0);
      end
      chk({mcu_ref_gate_q, mcu_pll_gate_q, mcu_run_q}, 3'h4);
      wait_for(2, 1'b1);
      chk(mcu_ref_gate_q, 1'b0);
      rchk(`RCS_OFS_SYS_STATUS, 32'h63);
      bus(1'b1, `RCS_OFS_MCU_CONTROL, 32'h1, 4'hf);
      wait_for(3, 1'b1);
      m_sel = $random(seed) & 32'hf;
      bus(1'b1, `RCS_OFS_CLOCK_SELECT, m_sel, 4'hf);
      @(posedge ref_clk);
      chk({frame_clock_src_q, display_synth_src_q}, m_sel);
      m_pend = $random(seed) & 32'hff;
      bus(1'b1, `RCS_OFS_DISP_PENDING, m_pend, 4'hf);
      bus(1'b1, `RCS_OFS_DISP_PENDING, ~m_pend, 4'he);
      rchk(`RCS_OFS_DISP_PENDING, m_pend);
      chk(disp_ctrl_q, 8'h00);
      update_evt <= 1'b1;
      @(posedge ref_clk);
      update_evt <= 1'b0;
      @(posedge ref_clk);
      chk(disp_ctrl_q, m_pend);
      bus(1'b1, `RCS_OFS_DISP_ACTIVE, ~m_pend, 4'hf);
      rchk(`RCS_OFS_DISP_ACTIVE, m_pend);
      m_stat = ($random(seed) & 32'hff) | 32'h81;
      status_evt <= m_stat[7:0];
      @(posedge ref_clk);
      status_evt <= 8'h00;
      rchk(`RCS_OFS_EVENT_STATUS, m_stat);
      w = $random(seed) & 32'hff;
      bus(1'b1, `RCS_OFS_EVENT_STATUS, w, 4'hf);
      m_stat = m_stat & ~w;
      rchk(`RCS_OFS_EVENT_STATUS, m_stat);
      bus(1'b1, `RCS_OFS_SYS_STATUS, 32'h0, 4'hf);
      rchk(`RCS_OFS_SYS_STATUS, 32'h67);
      ana_ref = ana_cnt;
      bus(1'b1, `RCS_OFS_HOST_CONTROL, `RCS_SOFT_RESET_START, 4'hf);
      wait_for(0, 1'b1);
      wait_for(0, 1'b0);
      chk(n >= 64 && n <= 65, 1'b1);
      bus(1'b1, `RCS_OFS_HOST_CONTROL, `RCS_SOFT_RESET_START, 4'hf);
      rchk(`RCS_OFS_HOST_CONTROL, 32'h1);
      bus(1'b1, `RCS_OFS_HOST_CONTROL, `RCS_SOFT_RESET_START, 4'hf);
      wait_for(0, 1'b0);
      chk(n <= 60, 1'b1);
      chk(ana_cnt, ana_ref);
      rchk(`RCS_OFS_HOST_CONTROL, 32'h0);
      chk(disp_ctrl_q, 8'h00);
      rchk(`RCS_OFS_DISP_ACTIVE, 32'h0);
      rchk(`RCS_OFS_DISP_PENDING, m_pend);
      rchk(`RCS_OFS_EVENT_STATUS, 32'h0);
      rchk(`RCS_OFS_CLOCK_SELECT, m_sel);
      rchk(`RCS_OFS_MCU_CONTROL, 32'h1);
      boot_autostart <= 1'b1;
      boot_clk_pll <= 1'b0;
      lock_dly <= 8'h01;
      pin_req <= 1'b1;
      @(posedge ref_clk);
      pin_req <= 1'b0;
      wait_for(1, 1'b0);
      wait_for(1, 1'b1);
      wait_for(0, 1'b0);
      rchk(`RCS_OFS_DISP_PENDING, 32'h0);
      rchk(`RCS_OFS_CLOCK_SELECT, 32'h0);
      rchk(`RCS_OFS_MCU_CONTROL, 32'h0);
      wait_for(3, 1'b1);
      chk({mcu_ref_gate_q, mcu_pll_gate_q}, 2'h2);
      test_done();
   end
endmodule : tb_top
